// ### rtl/p35fs_top.sv
// pin function select for ports 3, 4 and 5 with its apb register file
//
// Design decision made here: the APB interface to the registers.
`default_nettype none

module p35fs_top
    import p35fs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [3:0] boot_mode_pins,
    input wire logic [7:0] p3_pin_in,
    input wire logic [7:0] p3_port_data,
    output var p35fs_pin_type p3_pin,
    input wire logic [7:0] p4_pin_in,
    input wire logic [7:0] p4_port_data,
    output var p35fs_pin_type p4_pin,
    input wire logic [7:0] p5_pin_in,
    input wire logic [7:0] p5_port_data,
    output var p35fs_pin_type p5_pin,
    input wire logic timer_out0,
    input wire logic timer_out1,
    output logic timer_clear_in,
    output logic timer_count_in,
    output logic ext_irq_in0,
    output logic ext_irq_in1,
    output logic ext_irq_in2,
    output logic ext_irq_in3,
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe,
    output logic serial_clock_io,
    output logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic [15:0] ext_dbus_out,
    input wire logic ext_dbus_oe,
    output logic [15:0] ext_dbus_in,
    output logic p4_bus_active,
    output logic p5_bus_active
);

    // ========================================================================
    // helpers
    // ========================================================================
    // expansion field loaded from the boot strap
    function automatic logic [3:0] strap_exp(input logic [3:0] mode);
        if (mode == BOOT_ROMLESS0 || mode == BOOT_SINGLE1) begin
            return EXP_BUS16;
        end else if (mode == BOOT_ROMLESS1) begin
            return EXP_BUS8;
        end else begin
            return EXP_RST;
        end
    endfunction

    // port-mode drive: latch data out, buffer on when direction bit is zero
    function automatic p35fs_pin_type port_drive(input logic [7:0] data,
                                                 input logic [7:0] dir);
        p35fs_pin_type p;
        p.out = data;
        p.oe = ~dir;
        return p;
    endfunction

    // ========================================================================
    // register state
    // ========================================================================
    logic [7:0] p3fc_r, p3fc_nxt;
    logic [7:0] sersel_r, sersel_nxt;
    logic [3:0] exp_r, exp_nxt;
    logic [7:0] p3dir_r, p3dir_nxt;
    logic [7:0] p4dir_r, p4dir_nxt;
    logic [7:0] p5dir_r, p5dir_nxt;
    logic exp_loaded_r, exp_loaded_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [7:0] wdata8;
    logic [7:0] rd_byte;
    logic addr_hit;
    logic wr_en;
    logic rd_setup;

    assign wdata8 = pwdata[7:0];
    // zero-wait slave: the write lands at the access edge
    assign wr_en = psel & penable & pwrite & pstrb[0];
    assign rd_setup = psel & ~penable & ~pwrite;

    // address decode and read mux
    always_comb begin
        addr_hit = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            ADDR_P3FC: rd_byte = p3fc_r;
            ADDR_SERSEL: rd_byte = sersel_r & SERSEL_MASK;
            ADDR_EXPMODE: rd_byte = {4'h0, exp_r};
            ADDR_P3DIR: rd_byte = p3dir_r;
            ADDR_P4DIR: rd_byte = p4dir_r;
            ADDR_P5DIR: rd_byte = p5dir_r;
            ADDR_STATUS: rd_byte = {6'h00, p5_bus_active, p4_bus_active};
            default: addr_hit = 1'b0;
        endcase
    end

    // next register values
    always_comb begin
        p3fc_nxt = p3fc_r;
        sersel_nxt = sersel_r;
        exp_nxt = exp_r;
        p3dir_nxt = p3dir_r;
        p4dir_nxt = p4dir_r;
        p5dir_nxt = p5dir_r;
        exp_loaded_nxt = 1'b1;
        prdata_nxt = prdata_r;
        // read data is captured in the setup cycle so prdata is a flop
        if (rd_setup) begin
            prdata_nxt = {24'h000000, rd_byte};
        end
        if (wr_en) begin
            case (paddr)
                ADDR_P3FC: p3fc_nxt = wdata8;
                ADDR_SERSEL: sersel_nxt = wdata8 & SERSEL_MASK;
                ADDR_EXPMODE: exp_nxt = wdata8[3:0];
                ADDR_P3DIR: p3dir_nxt = wdata8;
                ADDR_P4DIR: p4dir_nxt = wdata8;
                ADDR_P5DIR: p5dir_nxt = wdata8;
                default: begin
                end
            endcase
        end
        // strap is caught on the first edge after release and beats a write
        if (!exp_loaded_r) begin
            exp_nxt = strap_exp(boot_mode_pins);
        end
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p3fc_r <= P3FC_RST;
            sersel_r <= SERSEL_RST;
            exp_r <= EXP_RST;
            p3dir_r <= DIR_RST;
            p4dir_r <= DIR_RST;
            p5dir_r <= DIR_RST;
            exp_loaded_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            p3fc_r <= p3fc_nxt;
            sersel_r <= sersel_nxt;
            exp_r <= exp_nxt;
            p3dir_r <= p3dir_nxt;
            p4dir_r <= p4dir_nxt;
            p5dir_r <= p5dir_nxt;
            exp_loaded_r <= exp_loaded_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // apb answer; unmapped addresses report an error and read zero
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = psel & penable & ~addr_hit;

    // ========================================================================
    // port 3 pin mux
    // ========================================================================
    logic ser_route;
    // route bit only matters where the function bit is set
    assign ser_route = sersel_r[SERIAL_ROUTE_BIT];

    always_comb begin
        p3_pin = port_drive(p3_port_data, p3dir_r);
        if (p3fc_r[P3_TOUT0]) begin
            p3_pin.out[P3_TOUT0] = timer_out0;
            p3_pin.oe[P3_TOUT0] = 1'b1;
        end
        if (p3fc_r[P3_TOUT1]) begin
            p3_pin.out[P3_TOUT1] = timer_out1;
            p3_pin.oe[P3_TOUT1] = 1'b1;
        end
        // input functions leave the buffer off
        if (p3fc_r[P3_TCLR]) begin
            p3_pin.oe[P3_TCLR] = 1'b0;
        end
        if (p3fc_r[P3_TCNT]) begin
            p3_pin.oe[P3_TCNT] = 1'b0;
        end
        if (p3fc_r[P3_IRQ0]) begin
            p3_pin.oe[P3_IRQ0] = 1'b0;
        end
        if (p3fc_r[P3_SDO]) begin
            p3_pin.out[P3_SDO] = serial_data_out;
            p3_pin.oe[P3_SDO] = ser_route;
        end
        if (p3fc_r[P3_SDI]) begin
            p3_pin.oe[P3_SDI] = 1'b0;
        end
        if (p3fc_r[P3_SCK]) begin
            p3_pin.out[P3_SCK] = serial_clock_out;
            p3_pin.oe[P3_SCK] = ser_route & serial_clock_oe;
        end
    end

    // peripheral inputs read zero when their pin is not assigned to them
    assign timer_clear_in = p3fc_r[P3_TCLR] & p3_pin_in[P3_TCLR];
    assign timer_count_in = p3fc_r[P3_TCNT] & p3_pin_in[P3_TCNT];
    assign ext_irq_in0 = p3fc_r[P3_IRQ0] & p3_pin_in[P3_IRQ0];
    assign ext_irq_in1 = p3fc_r[P3_SDO] & ~ser_route & p3_pin_in[P3_SDO];
    assign ext_irq_in2 = p3fc_r[P3_SDI] & ~ser_route & p3_pin_in[P3_SDI];
    assign ext_irq_in3 = p3fc_r[P3_SCK] & ~ser_route & p3_pin_in[P3_SCK];
    assign serial_data_in = p3fc_r[P3_SDI] & ser_route & p3_pin_in[P3_SDI];
    assign serial_clock_io = p3fc_r[P3_SCK] & ser_route & p3_pin_in[P3_SCK];

    // ========================================================================
    // ports 4 and 5: data bus or general port
    // ========================================================================
    // bit three is ignored for the low byte
    assign p4_bus_active = exp_r[EXP_P4_BIT];
    // a set bit three drops the upper byte lanes
    assign p5_bus_active = exp_r[EXP_P4_BIT] & ~exp_r[EXP_P5_OFF_BIT];

    // bus pins follow the bus cycle direction, not the direction register
    always_comb begin
        p4_pin = port_drive(p4_port_data, p4dir_r);
        p5_pin = port_drive(p5_port_data, p5dir_r);
        ext_dbus_in = 16'h0000;
        if (p4_bus_active) begin
            p4_pin.out = ext_dbus_out[7:0];
            p4_pin.oe = {8{ext_dbus_oe}};
            ext_dbus_in[7:0] = p4_pin_in;
        end
        if (p5_bus_active) begin
            p5_pin.out = ext_dbus_out[15:8];
            p5_pin.oe = {8{ext_dbus_oe}};
            ext_dbus_in[15:8] = p5_pin_in;
        end
    end

    // ========================================================================
    // assertions
    // ========================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_strap_romless0;
        !exp_loaded_r ##0 (boot_mode_pins == BOOT_ROMLESS0 || boot_mode_pins == BOOT_SINGLE1);
    endsequence

    sequence s_strap_romless1;
        !exp_loaded_r ##0 (boot_mode_pins == BOOT_ROMLESS1);
    endsequence

    p3fc_write_a: assert property (
        (wr_en && paddr == ADDR_P3FC) |=> (p3fc_r == $past(wdata8)))
        else $error("port 3 function register did not take the write");

    sersel_mask_a: assert property (
        (wr_en && paddr == ADDR_SERSEL) |=> (sersel_r == ($past(wdata8) & SERSEL_MASK)))
        else $error("serial select kept a fixed-zero bit");

    tout_route_a: assert property (
        p3fc_r[P3_TOUT0] |-> (p3_pin.out[P3_TOUT0] == timer_out0 && p3_pin.oe[P3_TOUT0]))
        else $error("timer output zero not on pin 0");

    tin_route_a: assert property (
        timer_count_in == (p3fc_r[P3_TCNT] && p3_pin_in[P3_TCNT]))
        else $error("timer count input misrouted");

    tclr_route_a: assert property (
        timer_clear_in == (p3fc_r[P3_TCLR] && p3_pin_in[P3_TCLR]))
        else $error("timer clear input misrouted");

    irq0_route_a: assert property (
        ext_irq_in0 == (p3fc_r[P3_IRQ0] && p3_pin_in[P3_IRQ0]))
        else $error("interrupt input zero misrouted");

    serial_route_a: assert property (
        (p3fc_r[P3_SDO] && ser_route) |->
            (p3_pin.out[P3_SDO] == serial_data_out && p3_pin.oe[P3_SDO] && !ext_irq_in1))
        else $error("serial data out not routed to pin 5");

    port_mode_a: assert property (
        !p3fc_r[P3_SCK] |->
            (p3_pin.out[P3_SCK] == p3_port_data[P3_SCK] && p3_pin.oe[P3_SCK] == !p3dir_r[P3_SCK]))
        else $error("port mode pin 7 not plain port");

    p4_bus_a: assert property (
        exp_r[EXP_P4_BIT] |-> (p4_bus_active && p4_pin.out == ext_dbus_out[7:0] &&
            ext_dbus_in[7:0] == p4_pin_in))
        else $error("port 4 does not carry the low data bus byte");

    p5_bus_a: assert property (
        p5_bus_active |-> (exp_r[EXP_P5_OFF_BIT] == 1'b0 && p5_pin.out == ext_dbus_out[15:8]))
        else $error("port 5 carries data bus with bit three set");

    bus_dir_a: assert property (
        p4_bus_active |-> (p4_pin.oe == {8{ext_dbus_oe}}))
        else $error("port 4 bus direction follows port bit");

    strap16_a: assert property (
        s_strap_romless0 |=> (exp_r == EXP_BUS16 && p5_bus_active))
        else $error("strap did not enable the 16-bit bus");

    strap8_a: assert property (
        s_strap_romless1 |=> (exp_r[2:0] == 3'h7) ##1 exp_loaded_r)
        else $error("strap did not enable expansion");

    dir_write_a: assert property (
        (wr_en && paddr == ADDR_P5DIR) |=> (p5dir_r == $past(wdata8)))
        else $error("port 5 direction register did not take the write");

endmodule

`default_nettype wire

// ### rtl/p35fs_pkg.sv
// constants and types shared by the port 3 to 5 function select block
`default_nettype none

package p35fs_pkg;

    // ========================================================================
    // register map
    // ========================================================================
    localparam int PADDR_W = 12;

    // word indices; the byte address is four times the index, cut to the bus width
    localparam logic [31:0] IDX_P3FC = 32'hFFFFF046;
    localparam logic [31:0] IDX_SERSEL = 32'hFFFFF047;
    localparam logic [31:0] IDX_EXPMODE = 32'hFFFFF048;
    localparam logic [31:0] IDX_P3DIR = 32'hFFFFF049;
    localparam logic [31:0] IDX_P4DIR = 32'hFFFFF04A;
    localparam logic [31:0] IDX_P5DIR = 32'hFFFFF04B;
    localparam logic [31:0] IDX_STATUS = 32'hFFFFF04C;

    function automatic logic [PADDR_W-1:0] p35fs_addr(input logic [31:0] idx);
        return {idx[PADDR_W-3:0], 2'b00};
    endfunction

    localparam logic [PADDR_W-1:0] ADDR_P3FC = p35fs_addr(IDX_P3FC);
    localparam logic [PADDR_W-1:0] ADDR_SERSEL = p35fs_addr(IDX_SERSEL);
    localparam logic [PADDR_W-1:0] ADDR_EXPMODE = p35fs_addr(IDX_EXPMODE);
    localparam logic [PADDR_W-1:0] ADDR_P3DIR = p35fs_addr(IDX_P3DIR);
    localparam logic [PADDR_W-1:0] ADDR_P4DIR = p35fs_addr(IDX_P4DIR);
    localparam logic [PADDR_W-1:0] ADDR_P5DIR = p35fs_addr(IDX_P5DIR);
    localparam logic [PADDR_W-1:0] ADDR_STATUS = p35fs_addr(IDX_STATUS);

    // ========================================================================
    // field positions
    // ========================================================================
    localparam int P3_TOUT0 = 0;
    localparam int P3_TOUT1 = 1;
    localparam int P3_TCLR = 2;
    localparam int P3_TCNT = 3;
    localparam int P3_IRQ0 = 4;
    localparam int P3_SDO = 5;
    localparam int P3_SDI = 6;
    localparam int P3_SCK = 7;
    localparam int SERIAL_ROUTE_BIT = 5;
    localparam int EXP_P4_BIT = 2;
    localparam int EXP_P5_OFF_BIT = 3;

    // ========================================================================
    // reset values and boot modes
    // ========================================================================
    localparam logic [7:0] P3FC_RST = 8'h00;
    localparam logic [7:0] SERSEL_RST = 8'h00;
    localparam logic [7:0] SERSEL_MASK = 8'h20;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [3:0] EXP_RST = 4'h0;
    localparam logic [3:0] EXP_BUS16 = 4'h7;
    localparam logic [3:0] EXP_BUS8 = 4'hF;
    localparam logic [3:0] BOOT_ROMLESS0 = 4'h0;
    localparam logic [3:0] BOOT_ROMLESS1 = 4'h1;
    localparam logic [3:0] BOOT_SINGLE1 = 4'h3;

    // one 8-pin group as driven toward the pads
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } p35fs_pin_type;

endpackage

`default_nettype wire

// ### bench/p35fs_partner.sv
// pad and peripheral model around the port 3 to 5 function select block
`default_nettype none

module p35fs_partner
    import p35fs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire p35fs_pin_type p3_pin,
    input wire p35fs_pin_type p4_pin,
    input wire p35fs_pin_type p5_pin,
    output logic [7:0] p3_pin_in,
    output logic [7:0] p4_pin_in,
    output logic [7:0] p5_pin_in,
    output logic timer_out0,
    output logic timer_out1,
    output logic serial_clock_out,
    output logic serial_clock_oe,
    output logic serial_data_out,
    output logic [15:0] ext_dbus_out,
    output logic ext_dbus_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] cnt_r;

    // ========================================================================
    // pattern source
    // ========================================================================
    // odd step flips many bits each cycle, so a stale level never passes as fresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h9E37;
        end
    end

    // pads: the driven level where the block drives, a moving pattern elsewhere
    assign p3_pin_in = (p3_pin.out & p3_pin.oe) | (~cnt_r[7:0] & ~p3_pin.oe);
    assign p4_pin_in = (p4_pin.out & p4_pin.oe) | (~cnt_r[15:8] & ~p4_pin.oe);
    assign p5_pin_in = (p5_pin.out & p5_pin.oe) | (~cnt_r[11:4] & ~p5_pin.oe);

    // peripheral and bus controller outputs, taken from bits of the moving pattern
    assign timer_out0 = cnt_r[1];
    assign timer_out1 = cnt_r[2];
    assign serial_clock_out = cnt_r[3];
    assign serial_clock_oe = cnt_r[4];
    assign serial_data_out = cnt_r[5];
    assign ext_dbus_out = {cnt_r[7:0], cnt_r[15:8]};
    assign ext_dbus_oe = cnt_r[6];
endmodule

`default_nettype wire

// ### bench/test_port3_to_5_function_select.sv
// self-checking bench for the port 3 to 5 function select block
`default_nettype none

module test_port3_to_5_function_select
    import p35fs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, boot_mode_pins;
    logic [7:0] p3_pin_in, p4_pin_in, p5_pin_in, p3_port_data, p4_port_data, p5_port_data;
    p35fs_pin_type p3_pin, p4_pin, p5_pin;
    logic timer_out0, timer_out1, timer_clear_in, timer_count_in;
    logic ext_irq_in0, ext_irq_in1, ext_irq_in2, ext_irq_in3;
    logic serial_clock_out, serial_clock_oe, serial_clock_io, serial_data_in, serial_data_out;
    logic [15:0] ext_dbus_out, ext_dbus_in;
    logic ext_dbus_oe, p4_bus_active, p5_bus_active;
    int num_errors, num_checks;

    p35fs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .boot_mode_pins, .p3_pin_in, .p3_port_data, .p3_pin,
        .p4_pin_in, .p4_port_data, .p4_pin, .p5_pin_in, .p5_port_data, .p5_pin,
        .timer_out0, .timer_out1, .timer_clear_in, .timer_count_in, .ext_irq_in0,
        .ext_irq_in1, .ext_irq_in2, .ext_irq_in3, .serial_clock_out, .serial_clock_oe,
        .serial_clock_io, .serial_data_in, .serial_data_out, .ext_dbus_out, .ext_dbus_oe,
        .ext_dbus_in, .p4_bus_active, .p5_bus_active);

    p35fs_partner far (.pclk, .presetn, .p3_pin, .p4_pin, .p5_pin, .p3_pin_in, .p4_pin_in,
        .p5_pin_in, .timer_out0, .timer_out1, .serial_clock_out, .serial_clock_oe,
        .serial_data_out, .ext_dbus_out, .ext_dbus_oe);

    // ========================================================================
    // shared tasks
    // ========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; answer taken only at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [PADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {24'h000000, d}, q, e);
    endtask

    task automatic rd(input logic [PADDR_W-1:0] a, input logic [7:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h00000000, q, e);
        chk({q[31:1], q[0] | e}, {24'h000000, x});
        chk({31'h00000000, e}, 32'h00000000);
    endtask

    // strap is sampled at the first edge after release, so leave two edges idle
    task automatic do_reset(input logic [3:0] mode);
        boot_mode_pins <= mode;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // ========================================================================
    // scenarios
    // ========================================================================
    task automatic t_boot();
        logic [3:0] x;
        for (int i = 0; i < 4; i++) begin
            x = (i == 2) ? EXP_RST : ((i == 1) ? EXP_BUS8 : EXP_BUS16);
            do_reset(i[3:0]);
            rd(ADDR_EXPMODE, {4'h0, x});
            chk({30'h0, p5_bus_active, p4_bus_active}, {30'h0, x[2] & ~x[3], x[2]});
        end
        rd(ADDR_P3FC, P3FC_RST);
        rd(ADDR_SERSEL, SERSEL_RST);
        rd(ADDR_P3DIR, DIR_RST);
        rd(ADDR_P4DIR, DIR_RST);
        rd(ADDR_P5DIR, DIR_RST);
        $display("TB: boot test done");
    endtask

    task automatic t_regs();
        logic [31:0] q;
        logic e;
        wr(ADDR_SERSEL, 8'hFF);
        rd(ADDR_SERSEL, SERSEL_MASK);
        pstrb <= 4'hE;
        wr(ADDR_P3FC, 8'hFF);
        pstrb <= 4'hF;
        rd(ADDR_P3FC, 8'h00);
        wr(ADDR_P3FC, 8'h01);
        apb(1'b0, ADDR_P3FC, 32'h0, q, e);
        wr(ADDR_P3FC, q[7:0] | 8'h02);
        apb(1'b1, 12'h200, 32'h000000FF, q, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h200, 32'h0, q, e);
        chk({q[31:1], e}, 32'h1);
        rd(ADDR_P3FC, 8'h03);
        $display("TB: register test done");
    endtask

    // expected port 3 pads and peripheral inputs from the function settings
    task automatic chk3(input logic [7:0] fc, input logic rt, input logic [7:0] dir);
        logic [7:0] oe, out, pin, per;
        pin = p3_pin_in;
        oe = ~dir & ~fc;
        out = p3_port_data;
        oe[1:0] = oe[1:0] | fc[1:0];
        out[1:0] = (fc[1:0] & {timer_out1, timer_out0}) | (~fc[1:0] & out[1:0]);
        if (rt) begin
            oe[5] = oe[5] | fc[5];
            out[5] = fc[5] ? serial_data_out : out[5];
            oe[7] = oe[7] | (fc[7] & serial_clock_oe);
            out[7] = fc[7] ? serial_clock_out : out[7];
        end
        per = {pin[7:6] & fc[7:6] & {2{rt}}, pin[7:2] & fc[7:2] & {~rt, ~rt, ~rt, 3'b111}};
        chk({p3_pin.oe, p3_pin.out & oe, serial_clock_io, serial_data_in, ext_irq_in3,
            ext_irq_in2, ext_irq_in1, ext_irq_in0, timer_count_in, timer_clear_in, 8'h00},
            {oe, out & oe, per[7:6], per[5:0], 8'h00});
    endtask

    task automatic t_p3();
        logic [7:0] fcs [4];
        logic [7:0] fc, dir;
        fcs = '{8'h00, 8'hFF, 8'h55, 8'hAA};
        for (int i = 0; i < 16; i++) begin
            fc = fcs[i % 4];
            dir = {8{i[3]}};
            p3_port_data <= p3_port_data + 8'h3B;
            wr(ADDR_P3FC, fc);
            wr(ADDR_SERSEL, {2'b00, i[2], 5'h1F});
            wr(ADDR_P3DIR, dir ^ 8'h0F);
            repeat (3) begin
                @(negedge pclk);
                chk3(fc, i[2], dir ^ 8'h0F);
            end
        end
        $display("TB: port 3 test done");
    endtask

    task automatic t_exp();
        logic b4, b5;
        logic [7:0] oe4, oe5;
        wr(ADDR_P4DIR, 8'h0F);
        wr(ADDR_P5DIR, 8'hF0);
        // the sweep runs from internal memory, so no fetch needs the lanes it drops
        for (int v = 0; v < 16; v++) begin
            wr(ADDR_EXPMODE, {4'h0, v[3:0]});
            b4 = v[EXP_P4_BIT];
            b5 = b4 & ~v[EXP_P5_OFF_BIT];
            repeat (3) begin
                @(negedge pclk);
                oe4 = b4 ? {8{ext_dbus_oe}} : 8'hF0;
                oe5 = b5 ? {8{ext_dbus_oe}} : 8'h0F;
                chk({p4_pin.oe, p4_pin.out & oe4, p5_pin.oe, p5_pin.out & oe5},
                    {oe4, (b4 ? ext_dbus_out[7:0] : p4_port_data) & oe4, oe5,
                    (b5 ? ext_dbus_out[15:8] : p5_port_data) & oe5});
                chk({14'h0, p5_bus_active, p4_bus_active, ext_dbus_in}, {14'h0, b5, b4,
                    b5 ? p5_pin_in : 8'h00, b4 ? p4_pin_in : 8'h00});
            end
            rd(ADDR_STATUS, {6'h00, b5, b4});
        end
        // releasing the bus pins: field rewritten and port 4 direction set
        wr(ADDR_EXPMODE, 8'h00);
        wr(ADDR_P4DIR, 8'hFF);
        rd(ADDR_STATUS, 8'h00);
        $display("TB: expansion test done");
    endtask

    task automatic close_out();
        $display("TB: checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ========================================================================
    // clock, main sequence and watchdog
    // ========================================================================
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        boot_mode_pins = 4'h0;
        p3_port_data = 8'hA5;
        p4_port_data = 8'h3C;
        p5_port_data = 8'hC3;
        num_errors = 0;
        num_checks = 0;
        t_boot();
        t_regs();
        t_p3();
        t_exp();
        close_out();
    end

    // the whole run needs well under 2000 cycles; 20000 leaves wide margin
    initial begin
        #800000;
        num_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        close_out();
    end
endmodule

`default_nettype wire
